// ===== core/swc_pkg.sv
// package of the sleep/wake interrupt controller: map, timing and types
// assumes the controller clock is the device oscillator, four phases a cycle
package swc_pkg;

    // ---------------------------------------------------------------
    // register map, byte addresses on the plain register port
    // ---------------------------------------------------------------
    localparam logic [3:0]  ADDR_CTRL   = 4'h0;
    localparam logic [3:0]  ADDR_STAT   = 4'h4;
    localparam logic [3:0]  ADDR_EVT    = 4'h8;
    localparam logic [3:0]  ADDR_MASK   = 4'hC;

    // ---------------------------------------------------------------
    // oscillator modes held in the control register
    // ---------------------------------------------------------------
    localparam logic [1:0]  LOW_POWER_CRYSTAL_MODE      = 2'h0;
    localparam logic [1:0]  CRYSTAL_OSC_MODE            = 2'h1;
    localparam logic [1:0]  FAST_CRYSTAL_OSC_MODE       = 2'h2;
    localparam logic [1:0]  RESISTOR_CAPACITOR_OSC_MODE = 2'h3;
    localparam logic [1:0]  CTRL_RST                    = 2'h1;

    // ---------------------------------------------------------------
    // event bits, shared by the event and mask registers
    // ---------------------------------------------------------------
    localparam int          EVT_W       = 3;
    localparam int          EVT_WAKE    = 0;
    localparam int          EVT_NULL    = 1;
    localparam int          EVT_SLEEP   = 2;
    localparam logic [2:0]  MASK_RST    = 3'h0;

    // ---------------------------------------------------------------
    // timing: oscillator start-up delay and instruction cycle
    // ---------------------------------------------------------------
    localparam int          CLK_NS      = 20;
    localparam int          TOSC_NS     = 20;
    localparam int          OST_TOSC    = 1024;
    localparam int          OST_NS      = OST_TOSC * TOSC_NS;
    localparam int          OST_CYC     = (OST_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0]  LAST_PHASE  = 2'h3;
    localparam int          DUMMY_CYC   = 2;
    localparam int          NSRC        = 8;
    localparam logic [12:0] IRQ_VECTOR  = 13'h0004;

    // instruction-flow commands handed to the core, one bit each
    typedef struct packed {
        logic prefetch;    // fetch PC + 1 while power-down executes
        logic exec_next;   // run the prefetched instruction
        logic dummy;       // dummy cycle before vectoring
        logic vector;      // branch to the interrupt vector now
        logic resume;      // go on in line after power-down
        logic nullify;     // power-down completes as no-operation
    } swc_flow_t;

endpackage

// ===== core/swc_ctrl.sv
// sleep/wake interrupt controller: power-down entry, wake and resume
// assumes interrupt sources and core share mclk_i; core presents the
// decoded power-down and watchdog-clear instructions in their Q1 phase
//
// Overview of operation
// - a source is pending when its enable and flag are both set
// - pending before power-down executes: instruction becomes a no-op
// - a nullified power-down leaves watchdog and both status flags alone
// - pending during or after power-down wakes the device at once
// - wake path: finish power-down, clear watchdog, set expiry, clear powerdown
// - crystal modes wait 1024 oscillator periods on wake; resistor mode does not
// - global enable set: run prefetched instruction, dummy cycles, then vector
// - global enable clear: continue in line after power-down, no vector
// - wake ignores the global enable, needs only the source enable
// - instruction at PC + 1 is prefetched while power-down executes
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps

module swc_ctrl (
    input  wire logic                     mclk_i,            // device oscillator
    input  wire logic                     rst_n_i,           // async reset, low
    input  wire logic [swc_pkg::NSRC-1:0] irq_enable_i,      // per-source enables
    input  wire logic [swc_pkg::NSRC-1:0] irq_flag_i,        // per-source flags
    input  wire logic                     global_irq_enable_i, // core global enable
    input  wire logic                     sleep_instr_i,     // power-down in execute
    input  wire logic                     watchdog_clear_instr_i, // clear in execute
    input  wire logic                     wdt_timeout_i,     // watchdog expiry pulse
    input  wire logic [3:0]               addr_i,            // register address
    input  wire logic [31:0]              wdata_i,           // register write data
    input  wire logic                     wr_i,              // write strobe
    input  wire logic                     rd_i,              // read strobe
    output logic      [31:0]              rdata_o,           // read data, next cycle
    output logic      [1:0]               phase_o,           // instruction phase
    output swc_pkg::swc_flow_t            flow_o,            // flow commands
    output logic      [12:0]              vector_addr_o,     // interrupt vector
    output logic                          osc_run_o,         // oscillator driver on
    output logic                          sleeping_o,        // core held in sleep
    output logic                          wdt_clear_o,       // watchdog+postscaler clear
    output logic                          expiry_status_flag_o,    // status flag
    output logic                          powerdown_status_flag_o, // status flag
    output logic                          irq_o              // level interrupt
);

    // ---------------------------------------------------------------
    // sequencer state
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN, ST_EXEC, ST_SLEEP, ST_OST, ST_NEXT, ST_DUMMY
    } swc_state_t;

    swc_state_t          state_ff;
    swc_state_t          nxt_state;
    logic [1:0]          phase_ff;
    logic [1:0]          nxt_phase;
    logic [10:0]         cnt_ff;
    logic [10:0]         nxt_cnt;
    swc_pkg::swc_flow_t  flow_ff;
    swc_pkg::swc_flow_t  nxt_flow;
    logic                wdt_clr_ff;
    logic                nxt_wdt_clr;
    logic                expiry_ff;
    logic                nxt_expiry;
    logic                pdown_ff;
    logic                nxt_pdown;
    logic [2:0]          new_evt;

    // register bank state
    logic [1:0]          ctrl_ff;
    logic [1:0]          nxt_ctrl;
    logic [2:0]          evt_ff;
    logic [2:0]          nxt_evt;
    logic [2:0]          mask_ff;
    logic [2:0]          nxt_mask;
    logic [31:0]         rdata_ff;
    logic [31:0]         nxt_rdata;

    logic                pending;
    logic                first_q;
    logic                last_q;
    logic                crystal;
    logic                wake;

    // ---------------------------------------------------------------
    // wake decode
    // ---------------------------------------------------------------
    // global enable deliberately absent: it steers only the resume path
    assign pending = |(irq_enable_i & irq_flag_i);
    assign first_q = (phase_ff == 2'h0);
    assign last_q  = (phase_ff == swc_pkg::LAST_PHASE);
    assign crystal = (ctrl_ff != swc_pkg::RESISTOR_CAPACITOR_OSC_MODE);
    // watchdog expiry during sleep also wakes; flags handle the difference
    assign wake    = pending | wdt_timeout_i;

    // next state of the wake path once power-down has completed
    function automatic swc_state_t wake_target(input logic xtal);
        wake_target = xtal ? ST_OST : ST_NEXT;
    endfunction

    // ---------------------------------------------------------------
    // sequencer: next values
    // ---------------------------------------------------------------
    always_comb begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_flow    = '0;
        nxt_wdt_clr = 1'b0;
        nxt_expiry  = expiry_ff;
        nxt_pdown   = pdown_ff;
        new_evt     = 3'h0;
        // phases stop while the oscillator is off or settling
        if (state_ff == ST_SLEEP || state_ff == ST_OST) begin
            nxt_phase = 2'h0;
        end else begin
            nxt_phase = phase_ff + 2'h1;
        end
        if (wdt_timeout_i) begin
            nxt_expiry = 1'b0;
        end
        case (state_ff)
            ST_RUN: begin
                if (first_q && watchdog_clear_instr_i) begin
                    nxt_wdt_clr = 1'b1;
                    nxt_expiry  = 1'b1;
                    nxt_pdown   = 1'b1;
                end
                if (first_q && sleep_instr_i) begin
                    if (pending) begin
                        // no clear, no flag change: the cycle is a no-op
                        nxt_flow.nullify          = 1'b1;
                        new_evt[swc_pkg::EVT_NULL] = 1'b1;
                    end else begin
                        nxt_state         = ST_EXEC;
                        nxt_flow.prefetch = 1'b1;
                    end
                end
            end
            ST_EXEC: begin
                nxt_flow.prefetch = ~last_q;
                if (last_q) begin
                    // power-down always finishes before any wake
                    nxt_wdt_clr = 1'b1;
                    nxt_expiry  = 1'b1;
                    nxt_pdown   = 1'b0;
                    new_evt[swc_pkg::EVT_SLEEP] = 1'b1;
                    if (pending) begin
                        nxt_state = wake_target(crystal);
                        nxt_cnt   = 11'h000;
                        new_evt[swc_pkg::EVT_WAKE] = 1'b1;
                    end else begin
                        nxt_state = ST_SLEEP;
                    end
                end
            end
            ST_SLEEP: begin
                if (wake) begin
                    nxt_state = wake_target(crystal);
                    nxt_cnt   = 11'h000;
                    new_evt[swc_pkg::EVT_WAKE] = 1'b1;
                end
            end
            ST_OST: begin
                if (cnt_ff == 11'(swc_pkg::OST_CYC - 1)) begin
                    nxt_state = ST_NEXT;
                    nxt_cnt   = 11'h000;
                end else begin
                    nxt_cnt = cnt_ff + 11'h001;
                end
            end
            ST_NEXT: begin
                nxt_flow.exec_next = ~last_q;
                if (last_q) begin
                    nxt_cnt = 11'h000;
                    if (global_irq_enable_i) begin
                        nxt_state      = ST_DUMMY;
                        nxt_flow.dummy = 1'b1;
                    end else begin
                        nxt_state       = ST_RUN;
                        nxt_flow.resume = 1'b1;
                    end
                end else if (first_q) begin
                    nxt_flow.exec_next = 1'b1;
                end
            end
            ST_DUMMY: begin
                nxt_flow.dummy = 1'b1;
                if (last_q) begin
                    if (cnt_ff == 11'(swc_pkg::DUMMY_CYC - 1)) begin
                        nxt_state       = ST_RUN;
                        nxt_flow.dummy  = 1'b0;
                        nxt_flow.vector = 1'b1;
                    end else begin
                        nxt_cnt = cnt_ff + 11'h001;
                    end
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    // sequencer registers; both status flags read one after power-up
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff   <= ST_RUN;
            phase_ff   <= 2'h0;
            cnt_ff     <= 11'h000;
            flow_ff    <= '0;
            wdt_clr_ff <= 1'b0;
            expiry_ff  <= 1'b1;
            pdown_ff   <= 1'b1;
        end else begin
            state_ff   <= nxt_state;
            phase_ff   <= nxt_phase;
            cnt_ff     <= nxt_cnt;
            flow_ff    <= nxt_flow;
            wdt_clr_ff <= nxt_wdt_clr;
            expiry_ff  <= nxt_expiry;
            pdown_ff   <= nxt_pdown;
        end
    end

    // ---------------------------------------------------------------
    // register bank: control, status, sticky events, mask
    // ---------------------------------------------------------------
    // an event landing in the clearing read survives: set beats clear
    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_mask  = mask_ff;
        nxt_evt   = evt_ff;
        nxt_rdata = 32'h0000_0000;
        if (wr_i && addr_i == swc_pkg::ADDR_CTRL) begin
            nxt_ctrl = wdata_i[1:0];
        end
        if (wr_i && addr_i == swc_pkg::ADDR_MASK) begin
            nxt_mask = wdata_i[2:0];
        end
        if (rd_i) begin
            case (addr_i)
                swc_pkg::ADDR_CTRL: nxt_rdata = {30'h0, ctrl_ff};
                swc_pkg::ADDR_STAT: nxt_rdata = {26'h0, state_ff, sleeping_o,
                                                 expiry_ff, pdown_ff};
                swc_pkg::ADDR_EVT: begin
                    nxt_rdata = {29'h0, evt_ff};
                    nxt_evt   = 3'h0;
                end
                swc_pkg::ADDR_MASK: nxt_rdata = {29'h0, mask_ff};
                default:            nxt_rdata = 32'h0000_0000;
            endcase
        end
        nxt_evt = nxt_evt | new_evt;
    end

    // register bank registers
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_ff  <= swc_pkg::CTRL_RST;
            mask_ff  <= swc_pkg::MASK_RST;
            evt_ff   <= 3'h0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            mask_ff  <= nxt_mask;
            evt_ff   <= nxt_evt;
            rdata_ff <= nxt_rdata;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign rdata_o                 = rdata_ff;
    assign phase_o                 = phase_ff;
    assign flow_o                  = flow_ff;
    assign vector_addr_o           = swc_pkg::IRQ_VECTOR;
    assign sleeping_o              = (state_ff == ST_SLEEP);
    // driver is off only while asleep; start-up delay runs it again
    assign osc_run_o               = (state_ff != ST_SLEEP);
    assign wdt_clear_o             = wdt_clr_ff;
    assign expiry_status_flag_o    = expiry_ff;
    assign powerdown_status_flag_o = pdown_ff;
    assign irq_o                   = |(evt_ff & mask_ff);

endmodule

// ===== verif/swc_ctrl_asserts.sv
// checker for the sleep/wake controller, watching its top-level ports only
// assumes one clock domain and flow commands registered one clock after cause
`timescale 1ns/1ps

module swc_ctrl_asserts (
    input  wire logic                     mclk_i,                  // device oscillator
    input  wire logic                     rst_n_i,                 // async reset, low
    input  wire logic [swc_pkg::NSRC-1:0] irq_enable_i,            // per-source enables
    input  wire logic [swc_pkg::NSRC-1:0] irq_flag_i,              // per-source flags
    input  wire logic                     global_irq_enable_i,     // core global enable
    input  wire logic                     sleep_instr_i,           // power-down in execute
    input  wire logic [1:0]               phase_o,                 // instruction phase
    input  wire swc_pkg::swc_flow_t       flow_o,                  // flow commands
    input  wire logic                     osc_run_o,               // oscillator driver on
    input  wire logic                     sleeping_o,              // core held in sleep
    input  wire logic                     wdt_clear_o,             // watchdog clear pulse
    input  wire logic                     expiry_status_flag_o,    // status flag
    input  wire logic                     powerdown_status_flag_o  // status flag
);
    logic pend;

    // enable and flag together, global enable deliberately ignored
    assign pend = |(irq_enable_i & irq_flag_i);

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    chk_null_cause: assert property (flow_o.nullify |-> $past(pend) && $past(sleep_instr_i))
        else $error("nullify without pending power-down");
    chk_null_quiet: assert property (flow_o.nullify |->
        (!wdt_clear_o && $stable(powerdown_status_flag_o) && $stable(expiry_status_flag_o))[*2])
        else $error("nullified power-down touched watchdog or flags");
    chk_sleep_flags: assert property ($rose(sleeping_o) |->
        wdt_clear_o && expiry_status_flag_o && !powerdown_status_flag_o)
        else $error("sleep entry without clear and flag update");
    chk_sleep_osc: assert property (sleeping_o |-> !osc_run_o && phase_o == 2'h0)
        else $error("oscillator or phase running in sleep");
    chk_pend_wake: assert property (sleeping_o && pend |-> ##1 !sleeping_o)
        else $error("pending source did not wake at once");
    chk_prefetch_run: assert property (sleep_instr_i && phase_o == 2'h0 && !sleeping_o && !pend
        |-> ##1 flow_o.prefetch [*3])
        else $error("no prefetch during power-down");
    chk_dummy_len: assert property ($rose(flow_o.dummy) |-> flow_o.dummy [*8] ##1 flow_o.vector)
        else $error("dummy cycles not followed by vector");
    chk_vec_gie: assert property (flow_o.vector |-> global_irq_enable_i && $past(flow_o.dummy))
        else $error("vector without global enable or dummy");
    chk_resume_gie: assert property (flow_o.resume |-> !global_irq_enable_i && !flow_o.dummy)
        else $error("in-line resume with global enable set");

    cov_null: cover property (flow_o.nullify);
    cov_vec: cover property (flow_o.vector);
    cov_res: cover property (flow_o.resume);
    cov_sleep: cover property ($rose(sleeping_o));
endmodule

bind swc_ctrl swc_ctrl_asserts swc_ctrl_asserts_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .irq_enable_i(irq_enable_i), .irq_flag_i(irq_flag_i),
    .global_irq_enable_i(global_irq_enable_i), .sleep_instr_i(sleep_instr_i),
    .phase_o(phase_o), .flow_o(flow_o), .osc_run_o(osc_run_o), .sleeping_o(sleeping_o),
    .wdt_clear_o(wdt_clear_o), .expiry_status_flag_o(expiry_status_flag_o),
    .powerdown_status_flag_o(powerdown_status_flag_o));

// ===== verif/swc_core_model.sv
// core stand-in: issues watchdog-clear and power-down instructions on request
// assumes phase_i is the controller's phase, counting 0..3 while running
`timescale 1ns/1ps

module swc_core_model (
    input  wire logic       mclk_i,          // device oscillator
    input  wire logic       rst_n_i,         // async reset, low
    input  wire logic [1:0] phase_i,         // instruction phase
    input  wire logic       go_i,            // request one power-down
    input  wire logic       clr_first_i,     // clear watchdog before it
    output logic            sleep_instr_o,   // power-down in execute
    output logic            wdt_clr_instr_o  // watchdog-clear in execute
);
    logic want_ff;
    logic clr_ff;

    // an instruction is raised after phase 3 so it stands through phase 0
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            want_ff         <= 1'b0;
            clr_ff          <= 1'b0;
            sleep_instr_o   <= 1'b0;
            wdt_clr_instr_o <= 1'b0;
        end else begin
            sleep_instr_o   <= 1'b0;
            wdt_clr_instr_o <= 1'b0;
            if (go_i) begin
                want_ff <= 1'b1;
                clr_ff  <= clr_first_i;
            end else if (want_ff && phase_i == 2'h3) begin
                if (clr_ff) begin
                    wdt_clr_instr_o <= 1'b1;
                    clr_ff          <= 1'b0;
                end else begin
                    sleep_instr_o <= 1'b1;
                    want_ff       <= 1'b0;
                end
            end
        end
    end
endmodule

// ===== verif/tb_swc_ctrl.sv
// bench for the sleep/wake controller: power-down cases against a counting model
// assumes the core stand-in and the checker bind come with the design
`timescale 1ns/1ps

module tb_swc_ctrl;
    logic               mclk_i = 1'b0;
    logic               rst_n_i = 1'b0;
    logic [7:0]         en = 8'h00;
    logic [7:0]         flg = 8'h00;
    logic               global_irq_enable = 1'b0;
    logic               wto = 1'b0;
    logic [3:0]         addr_i = 4'h0;
    logic [31:0]        wdata_i = 32'h0;
    logic               wr_i = 1'b0;
    logic               rd_i = 1'b0;
    logic               go = 1'b0;
    logic               clr_first = 1'b0;
    logic               slp, wclr, osc, sleeping, wdt_clr, expiry, pd, irq;
    logic [31:0]        rdata_o;
    logic [1:0]         phase_o;
    logic [12:0]        vec;
    swc_pkg::swc_flow_t flow_o;
    int                 bad_count = 0;
    int                 n_tests = 0;
    int                 cyc = 0;

    swc_ctrl swc_ctrl_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .irq_enable_i(en), .irq_flag_i(flg),
        .global_irq_enable_i(global_irq_enable), .sleep_instr_i(slp), .watchdog_clear_instr_i(wclr),
        .wdt_timeout_i(wto), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .phase_o(phase_o), .flow_o(flow_o), .vector_addr_o(vec),
        .osc_run_o(osc), .sleeping_o(sleeping), .wdt_clear_o(wdt_clr),
        .expiry_status_flag_o(expiry), .powerdown_status_flag_o(pd), .irq_o(irq));
    swc_core_model swc_core_model_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .phase_i(phase_o),
        .go_i(go), .clr_first_i(clr_first), .sleep_instr_o(slp), .wdt_clr_instr_o(wclr));

    // clock and a hang guard well above six cases, the three crystal wakes of about 1.1k cycles each
    initial forever #10 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, m, got, exp);
        end
    endtask

    // register port: one-cycle strobes, read data in the cycle after
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(posedge mclk_i);
        d = rdata_o;
    endtask

    // when: 0 pending before, 1 during, 2 after entry, 3 watchdog wake
    task automatic run_case(input logic [1:0] mode, input logic g, input int when);
        logic [31:0] d;
        logic [7:0]  e;
        logic [2:0]  m, ev;
        logic        pd0, to0, raised, done, nul, vecd, res;
        int          k, t0, lat, nw, nd, nx;
        k = $urandom % 8;
        e = 8'($urandom) | (8'h01 << k);
        m = 3'($urandom);
        // a flag raised inside power-down still logs the completed entry
        ev = (when == 0) ? 3'h2 : 3'h5;
        {raised, done, nul, vecd, res, t0, lat, nw, nd, nx} = '0;
        wr(swc_pkg::ADDR_CTRL, {30'h0, mode});
        wr(swc_pkg::ADDR_MASK, {29'h0, m});
        rd(swc_pkg::ADDR_EVT, d);
        en  <= e;
        flg <= (8'($urandom) & ~e) | ((when == 0) ? (8'h01 << k) : 8'h00);
        global_irq_enable <= g;
        clr_first <= (when != 0);
        go  <= 1'b1;
        pd0 = pd;
        to0 = expiry;
        for (int i = 0; i < 1500 && !done; i++) begin
            @(posedge mclk_i);
            go  <= 1'b0;
            // one assignment per edge: the expiry pulse lasts exactly one cycle
            wto <= (!raised && when == 3 && sleeping);
            nw += wdt_clr;
            nd += flow_o.dummy;
            nx += flow_o.exec_next;
            if (!raised && ((when == 1 && flow_o.prefetch) || (when > 1 && sleeping))) begin
                raised = 1'b1;
                t0 = i;
                if (when != 3) flg <= flg | (8'h01 << k);
            end
            {nul, vecd, res} = {flow_o.nullify, flow_o.vector, flow_o.resume};
            done = nul | vecd | res;
            lat = i - t0;
        end
        flg <= 8'h00;
        repeat (2) @(posedge mclk_i);
        chk(nul, when == 0, "nullify");
        chk(vecd, when != 0 && g, "vector");
        chk(res, when != 0 && !g, "resume");
        chk(nd, (when != 0 && g) ? swc_pkg::DUMMY_CYC * 4 : 0, "dummy cycles");
        chk(nx > 0, when != 0, "exec next");
        chk(nw, (when == 0) ? 0 : 2, "watchdog clears");
        chk(pd, (when == 0) ? pd0 : 1'b0, "powerdown flag");
        chk(expiry, (when == 0) ? to0 : (when != 3), "expiry flag");
        if (when >= 2) chk(mode == swc_pkg::RESISTOR_CAPACITOR_OSC_MODE ? lat < 40 :
            (lat >= swc_pkg::OST_CYC && lat < swc_pkg::OST_CYC + 40), 1, "wake delay");
        chk(irq, |(ev & m), "irq level");
        rd(swc_pkg::ADDR_EVT, d);
        chk(d, {29'h0, ev}, "events");
        rd(swc_pkg::ADDR_EVT, d);
        chk(d, 32'h0, "events cleared");
        chk(irq, 1'b0, "irq after read");
    endtask

    initial begin
        logic [31:0] d;
        void'($urandom(32'h283D));
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(swc_pkg::ADDR_CTRL, d);
        chk(d, {30'h0, swc_pkg::CTRL_RST}, "ctrl reset");
        rd(swc_pkg::ADDR_MASK, d);
        chk(d, {29'h0, swc_pkg::MASK_RST}, "mask reset");
        rd(swc_pkg::ADDR_STAT, d);
        chk(d, 32'h3, "status reset");
        wr(4'h2, 32'hFFFFFFFF);
        rd(4'h2, d);
        chk(d, 32'h0, "unmapped");
        chk(vec, swc_pkg::IRQ_VECTOR, "vector address");
        chk(osc, 1'b1, "oscillator on");
        run_case(swc_pkg::CRYSTAL_OSC_MODE, 1'b0, 0);
        run_case(swc_pkg::LOW_POWER_CRYSTAL_MODE, 1'b1, 1);
        run_case(swc_pkg::FAST_CRYSTAL_OSC_MODE, 1'b1, 2);
        run_case(swc_pkg::RESISTOR_CAPACITOR_OSC_MODE, 1'b0, 2);
        run_case(swc_pkg::RESISTOR_CAPACITOR_OSC_MODE, 1'b1, 3);
        run_case(swc_pkg::CRYSTAL_OSC_MODE, 1'b0, 3);
        end_sim();
    end
endmodule
